//--- dv/pci_cpu_model.sv
`timescale 1ns/1ps

// Stand-in for the CPU interrupt logic: enters the routine of the lowest requesting group.
module pci_cpu_model (
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Request and acknowledge.
    input  wire pci_pkg::pci_grp_t group_request,
    input  wire logic              ack_en,
    input  wire logic [3:0]        ack_delay,
    output pci_pkg::pci_grp_t      vector_ack
);
    logic [3:0] wait_r;

    // The cycle after a pulse is skipped, since the request it served is still seen then.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_r     <= 4'h0;
            vector_ack <= 3'h0;
        end
        else
        begin
            vector_ack <= 3'h0;
            wait_r     <= 4'h0;
            if (ack_en && group_request != 3'h0 && vector_ack == 3'h0)
            begin
                if (wait_r == ack_delay)
                    vector_ack <= group_request & (~group_request + 3'h1);
                else
                    wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

//--- dv/pin_change_interrupt_unit_test.sv
`timescale 1ns/1ps
`include "pci_defs.svh"
`define PCI_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module pin_change_interrupt_unit_test;
    logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, ack_en;
    logic [1:0]        htrans;
    logic [2:0]        hsize, ctrl_s, flags_s;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [23:0]       pins;
    logic [3:0]        ack_delay;
    logic [7:0]        lfsr_r, k;
    logic              gie_s;
    logic              rd_phase = 1'b0;
    logic [35:0]       exp_q[$];
    pci_pkg::pci_grp_t vector_ack, group_request;
    int                err_count, checks_done, cycles;
    logic [7:0]        idx_tab[0:6] = '{8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h69};

    // Single slave, so its ready is the bus ready.
    assign hready = hreadyout;

    pci_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .watched_pins_group0(pins[7:0]),
        .watched_pins_group1(pins[15:8]), .watched_pins_group2(pins[23:16]),
        .vector_ack(vector_ack), .group_request(group_request), .irq(irq));

    pci_cpu_model u_cpu (.hclk(hclk), .hresetn(hresetn), .group_request(group_request),
        .ack_en(ack_en), .ack_delay(ack_delay), .vector_ack(vector_ack));

    // Clock at 40 MHz.
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One single transfer; no wait count is assumed, only the timeout ends a stall.
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    // Shadow state follows control, global enable and flag writes so interrupt outputs can be predicted.
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        if (idx == `PCI_IDX_CTRL)
            ctrl_s = d[2:0];
        if (idx == `PCI_IDX_GIE)
            gie_s = d[0];
        if (idx == `PCI_IDX_FLAGS)
            flags_s = flags_s & ~d[2:0];
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back({|(flags_s & ctrl_s), flags_s & ctrl_s & {3{gie_s}}, e});
        bus(idx, 1'b0, 32'h0);
    endtask

    task automatic toggle(input int pin);
        @(posedge hclk);
        pins <= pins ^ (24'h1 << pin);
        repeat (6) @(posedge hclk);
    endtask

    // Watcher: read data and interrupt outputs are judged at the end of each read data phase.
    always @(posedge hclk)
    begin
        if (rd_phase && hready === 1'b1)
            `PCI_CHK({irq, group_request, hrdata}, exp_q.pop_front())
        rd_phase <= hsel && htrans == 2'h2 && !hwrite && hready;
    end

    // A hang ends the run as a failure.
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        {hresetn, hsel, hwrite, ack_en, htrans, haddr, hwdata, pins, ack_delay} = '0;
        hsize = 3'h2;
        {ctrl_s, flags_s, gie_s} = '0;
        lfsr_r = 8'h04;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (idx_tab[i]) rd(idx_tab[i], 32'h0);
        // Random masks read back; upper bits and an unmapped word read zero.
        for (int g = 0; g < 3; g++)
        begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(`PCI_IDX_MASK0 + 8'(g), {24'hFFFFFF, lfsr_r});
            rd(`PCI_IDX_MASK0 + 8'(g), {24'h0, lfsr_r});
        end
        wr(8'h69, 32'hFFFFFFFF);
        rd(8'h69, 32'h0);
        wr(`PCI_IDX_GIE, 32'h1);
        for (int g = 0; g < 3; g++)
        begin
            lfsr_r = lfsr_next(lfsr_r);
            k = {5'h0, lfsr_r[2:0]};
            wr(`PCI_IDX_MASK0 + 8'(g), 32'h1 << k);
            wr(`PCI_IDX_CTRL, 32'hFFFFFFF8 | (32'h1 << g));
            toggle(8 * g + (k + 1) % 8);
            rd(`PCI_IDX_FLAGS, 32'h0);
            toggle(8 * g + k);
            flags_s[g] = 1'b1;
            rd(`PCI_IDX_FLAGS, {29'h0, flags_s});
            wr(`PCI_IDX_FLAGS, 32'h0);
            rd(`PCI_IDX_FLAGS, {29'h0, flags_s});
            wr(`PCI_IDX_FLAGS, 32'h1 << g);
            rd(`PCI_IDX_FLAGS, 32'h0);
            wr(`PCI_IDX_MASK0 + 8'(g), 32'h0);
        end
        // Group disabled: the change is lost, and enabling later raises nothing.
        wr(`PCI_IDX_MASK0, 32'hFF);
        wr(`PCI_IDX_CTRL, 32'h0);
        toggle(3);
        wr(`PCI_IDX_CTRL, 32'h1);
        rd(`PCI_IDX_FLAGS, 32'h0);
        // Global enable off: flag and irq rise, the vector request stays low.
        wr(`PCI_IDX_GIE, 32'h0);
        toggle(5);
        flags_s[0] = 1'b1;
        rd(`PCI_IDX_FLAGS, 32'h1);
        // Entering the routine clears the flag, with a prompt and a slow acknowledge.
        ack_en <= 1'b1;
        for (int d = 0; d < 16; d += 15)
        begin
            ack_delay <= 4'(d);
            wr(`PCI_IDX_GIE, 32'h1);
            toggle(6);
            repeat (20) @(posedge hclk);
            flags_s = 3'h0;
            rd(`PCI_IDX_FLAGS, 32'h0);
            wr(`PCI_IDX_GIE, 32'h0);
        end
        repeat (3) @(posedge hclk);
        print_verdict();
    end
endmodule

//--- rtl/pci_defs.svh
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

// Function
// [RL1] Enabled change on a group-one pin sets the group-one change flag.
// [RL2] Enabled change on a group-zero pin sets the group-zero change flag.
// [RL3] Set flag, group enable and global enable together request that group's vector.
// [RL4] Entering a group's service routine clears that group's change flag.
// [RL5] Writing one to a flag bit clears it; writing zero leaves it.
// [RL6] Group-two mask bits enable change detection on pins 16 to 23.
// [RL7] A cleared mask bit keeps its pin out of the group flag.
// [RL8] Group-one mask bits enable change detection on pins 8 to 15.
// [RL9] Group-zero mask bits enable change detection on pins 0 to 7.
// [RL10] Control bits 2 to 0 enable the three groups.
// [RL11] Enabled change on a group-two pin sets flag bit 2.
// [RL12] A change is a synchronised sample differing from the previous cycle's sample.

// Register indices; the byte address is four times the index.
`define PCI_IDX_CTRL   8'h68
`define PCI_IDX_MASK0  8'h6B
`define PCI_IDX_MASK1  8'h6C
`define PCI_IDX_MASK2  8'h6D
`define PCI_IDX_FLAGS  8'h6E
`define PCI_IDX_GIE    8'h6F

// Byte addresses on the bus.
`define PCI_ADDR_CTRL  {22'h000000, `PCI_IDX_CTRL, 2'h0}
`define PCI_ADDR_MASK0 {22'h000000, `PCI_IDX_MASK0, 2'h0}
`define PCI_ADDR_FLAGS {22'h000000, `PCI_IDX_FLAGS, 2'h0}
`define PCI_ADDR_GIE   {22'h000000, `PCI_IDX_GIE, 2'h0}

// Field layout.
`define PCI_NGRP       3
`define PCI_GRP_W      8
`define PCI_NPIN       24
`define PCI_GIE_BIT    0

// Reset values.
`define PCI_RST_MASK   8'h00
`define PCI_RST_CTRL   3'h0
`define PCI_RST_FLAGS  3'h0
`define PCI_RST_GIE    1'h0
`define PCI_RST_PIN    24'h000000

// Bus encodings.
`define PCI_HTRANS_NONSEQ 2'h2
`define PCI_HRESP_OKAY    1'h0

`endif

//--- rtl/pci_pkg.sv
package pci_pkg;

    // One bit per pin group.
    typedef logic [2:0] pci_grp_t;

    // Eight pins or mask bits of one group.
    typedef logic [7:0] pci_byte_t;

    // Address phase held over into the data phase.
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [31:0] addr;
    } pci_cmd_s;

endpackage

//--- rtl/pci_sync.sv
`timescale 1ns/1ps
`include "pci_defs.svh"

module pci_sync (
    // Clock and reset.
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // Raw pins and per-pin change events.
    input  wire logic [`PCI_NPIN-1:0]    pins,
    output logic      [`PCI_NPIN-1:0]    change
);

    logic [`PCI_NPIN-1:0] meta_r;
    logic [`PCI_NPIN-1:0] sync_r;
    logic [`PCI_NPIN-1:0] prev_r;
    logic [1:0]           warm_r;

    genvar k;
    // Each pin passes two flops, then a third holds last cycle's sample.
    for (k = 0; k < `PCI_NPIN; k++)
    begin : g_pin
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                meta_r[k] <= 1'b0;
                sync_r[k] <= 1'b0;
                prev_r[k] <= 1'b0;
            end
            else
            begin
                meta_r[k] <= pins[k];
                sync_r[k] <= meta_r[k];
                prev_r[k] <= sync_r[k];
            end
        end
        // [RL12] sample versus previous
        assign change[k] = sync_r[k] ^ prev_r[k];
    end

    // Counts the first cycles after reset, when the pipeline is not yet full.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            warm_r <= 2'h0;
        else if (warm_r != 2'h3)
            warm_r <= warm_r + 2'h1;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_change_detect;
        (warm_r == 2'h3) |-> (change == ($past(pins, 2) ^ $past(pins, 3)));
    endproperty
    a_change_detect: assert property (p_change_detect) // [RL12]
        else $error("Pin change event does not match pin history.");

endmodule

//--- rtl/pci_top.sv
`timescale 1ns/1ps
`include "pci_defs.svh"

module pci_top (
    // Clock and reset.
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave.
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic      [31:0]          hrdata,
    // Watched pins.
    input  wire pci_pkg::pci_byte_t   watched_pins_group0,
    input  wire pci_pkg::pci_byte_t   watched_pins_group1,
    input  wire pci_pkg::pci_byte_t   watched_pins_group2,
    // CPU interrupt logic.
    input  wire pci_pkg::pci_grp_t    vector_ack,
    output pci_pkg::pci_grp_t         group_request,
    output logic                      irq
);

    // Register state.
    logic [2:0][7:0]         mask_r;
    logic [2:0][7:0]         mask_nxt;
    pci_pkg::pci_grp_t       ctrl_r;
    pci_pkg::pci_grp_t       ctrl_nxt;
    pci_pkg::pci_grp_t       flags_r;
    pci_pkg::pci_grp_t       flags_nxt;
    logic                    gie_r;
    logic                    gie_nxt;
    pci_pkg::pci_cmd_s       cmd_r;
    pci_pkg::pci_cmd_s       cmd_nxt;

    // Output flops.
    logic                    hreadyout_r;
    logic                    hresp_r;
    logic [31:0]             hrdata_r;
    logic [31:0]             hrdata_nxt;
    pci_pkg::pci_grp_t       req_r;
    pci_pkg::pci_grp_t       req_nxt;
    logic                    irq_r;
    logic                    irq_nxt;

    // Decode and event wires.
    logic [`PCI_NPIN-1:0]    change;
    logic                    addr_phase;
    logic                    wr_en;
    logic                    ctrl_wr;
    logic                    flags_wr;
    logic                    gie_wr;
    pci_pkg::pci_grp_t       mask_wr;
    pci_pkg::pci_grp_t       masked_any;
    pci_pkg::pci_grp_t       grp_hit;
    pci_pkg::pci_grp_t       flag_clr;
    pci_pkg::pci_grp_t       w1c_bits;
    logic                    rd_ctrl;
    logic                    rd_flags;
    logic                    rd_gie;
    pci_pkg::pci_grp_t       rd_mask;
    logic [31:0]             rd_word;

    // Pins are asynchronous to hclk, so they are synchronised before use.
    pci_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    ({watched_pins_group2, watched_pins_group1, watched_pins_group0}),
        .change  (change)
    );

    // Address phase is taken on a selected NONSEQ transfer with hready high.
    assign addr_phase = hsel & (htrans == `PCI_HTRANS_NONSEQ) & hready;
    assign cmd_nxt.valid = addr_phase;
    assign cmd_nxt.wr    = hwrite;
    assign cmd_nxt.addr  = haddr;

    // Writes complete in the data phase, when hwdata is on the bus.
    assign wr_en    = cmd_r.valid & cmd_r.wr;
    assign ctrl_wr  = wr_en & (cmd_r.addr == `PCI_ADDR_CTRL);
    assign flags_wr = wr_en & (cmd_r.addr == `PCI_ADDR_FLAGS);
    assign gie_wr   = wr_en & (cmd_r.addr == `PCI_ADDR_GIE);

    // [RL10] group enable bits
    assign ctrl_nxt = ctrl_wr ? hwdata[2:0] : ctrl_r;
    assign gie_nxt  = gie_wr ? hwdata[`PCI_GIE_BIT] : gie_r;

    // Only the written ones clear; a zero leaves its flag alone.
    assign w1c_bits = flags_wr ? hwdata[2:0] : 3'h0;

    genvar g;
    // One slice per group: mask register, detection and flag.
    for (g = 0; g < `PCI_NGRP; g++)
    begin : g_grp
        localparam logic [31:0] MADDR = `PCI_ADDR_MASK0 + 32'(4 * g);

        assign mask_wr[g]  = wr_en & (cmd_r.addr == MADDR);
        assign mask_nxt[g] = mask_wr[g] ? hwdata[7:0] : mask_r[g];
        assign rd_mask[g]  = (haddr == MADDR);

        // [RL6] [RL8] [RL9] per-pin enable
        // [RL7] cleared bit blocks
        assign masked_any[g] = |(change[`PCI_GRP_W*g +: `PCI_GRP_W] & mask_r[g]);

        // [RL10] group gates detection
        assign grp_hit[g] = ctrl_r[g] & masked_any[g];

        // [RL4] [RL5] service or write-one
        assign flag_clr[g] = vector_ack[g] | w1c_bits[g];

        // [RL1] [RL2] [RL11] set beats clear
        assign flags_nxt[g] = grp_hit[g] | (flags_r[g] & ~flag_clr[g]);
    end

    // [RL3] vector request per group
    assign req_nxt = flags_nxt & ctrl_nxt & {`PCI_NGRP{gie_nxt}};

    // The summary line ignores the global enable: it follows the flags and group enables only.
    assign irq_nxt = |(flags_nxt & ctrl_nxt);

    // Read decode looks at the address phase.
    assign rd_ctrl  = (haddr == `PCI_ADDR_CTRL);
    assign rd_flags = (haddr == `PCI_ADDR_FLAGS);
    assign rd_gie   = (haddr == `PCI_ADDR_GIE);

    // Reads sample next-state values, so a write just ahead is already visible.
    assign rd_word = rd_ctrl    ? {29'h0, ctrl_nxt}  :
                     rd_flags   ? {29'h0, flags_nxt} :
                     rd_gie     ? {31'h0, gie_nxt}   :
                     rd_mask[0] ? {24'h0, mask_nxt[0]} :
                     rd_mask[1] ? {24'h0, mask_nxt[1]} :
                     rd_mask[2] ? {24'h0, mask_nxt[2]} :
                     32'h0;
    assign hrdata_nxt = (addr_phase & ~hwrite) ? rd_word : 32'h0;

    // Bus side state.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_r       <= '0;
            hrdata_r    <= 32'h0;
            hreadyout_r <= 1'b1;
            hresp_r     <= `PCI_HRESP_OKAY;
        end
        else
        begin
            cmd_r       <= cmd_nxt;
            hrdata_r    <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r     <= `PCI_HRESP_OKAY;
        end
    end

    // Control and mask registers.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mask_r <= {`PCI_RST_MASK, `PCI_RST_MASK, `PCI_RST_MASK};
            ctrl_r <= `PCI_RST_CTRL;
            gie_r  <= `PCI_RST_GIE;
        end
        else
        begin
            mask_r <= mask_nxt;
            ctrl_r <= ctrl_nxt;
            gie_r  <= gie_nxt;
        end
    end

    // Sticky flags and the interrupt outputs.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flags_r <= `PCI_RST_FLAGS;
            req_r   <= 3'h0;
            irq_r   <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            req_r   <= req_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Every output leaves straight from a flop.
    assign hreadyout     = hreadyout_r;
    assign hresp         = hresp_r;
    assign hrdata        = hrdata_r;
    assign group_request = req_r;
    assign irq           = irq_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Helpers that only the checks below read.
    pci_pkg::pci_grp_t ack_only;
    pci_pkg::pci_grp_t quiet_clear;
    assign ack_only    = vector_ack & ~grp_hit;
    assign quiet_clear = ~flags_r & ~masked_any;

    // A flag write in its data phase with no competing event.
    sequence s_flag_write;
        flags_wr && (grp_hit == 3'h0) && (vector_ack == 3'h0);
    endsequence

    // Group zero hit, seen as a flag one edge later.
    sequence s_hit0;
        grp_hit[0] ##1 flags_r[0];
    endsequence

    property p_grp0_set;
        grp_hit[0] |-> s_hit0;
    endproperty
    a_grp0_set: assert property (p_grp0_set) // [RL2]
        else $error("Group zero change did not set its flag.");

    property p_grp1_set;
        grp_hit[1] |=> flags_r[1] && irq;
    endproperty
    a_grp1_set: assert property (p_grp1_set) // [RL1]
        else $error("Group one change did not set its flag and interrupt.");

    property p_grp2_set;
        grp_hit[2] && !gie_r && !gie_wr |=> flags_r[2] && !group_request[2];
    endproperty
    a_grp2_set: assert property (p_grp2_set) // [RL11]
        else $error("Group two flag wrong or request without global enable.");

    property p_vector_req;
        group_request == (flags_r & ctrl_r & {3{gie_r}});
    endproperty
    a_vector_req: assert property (p_vector_req) // [RL3]
        else $error("Vector request does not follow flag and enables.");

    property p_ack_clear;
        (ack_only != 3'h0) |=> ((flags_r & $past(ack_only)) == 3'h0);
    endproperty
    a_ack_clear: assert property (p_ack_clear) // [RL4]
        else $error("Service entry did not clear the group flag.");

    property p_w1c;
        s_flag_write |=> (flags_r == ($past(flags_r) & ~$past(w1c_bits)));
    endproperty
    a_w1c: assert property (p_w1c) // [RL5]
        else $error("Flag write did not clear exactly the written ones.");

    property p_mask2;
        ctrl_r[2] && ((change[23:16] & mask_r[2]) != 8'h00) |=> flags_r[2];
    endproperty
    a_mask2: assert property (p_mask2) // [RL6]
        else $error("Enabled group two pin change was lost.");

    property p_mask1;
        ctrl_r[1] && ((change[15:8] & mask_r[1]) != 8'h00) |=> flags_r[1];
    endproperty
    a_mask1: assert property (p_mask1) // [RL8]
        else $error("Enabled group one pin change was lost.");

    property p_mask0;
        ctrl_r[0] && ((change[7:0] & mask_r[0]) != 8'h00) |=> flags_r[0];
    endproperty
    a_mask0: assert property (p_mask0) // [RL9]
        else $error("Enabled group zero pin change was lost.");

    property p_masked_off;
        (quiet_clear != 3'h0) |=> ((flags_r & $past(quiet_clear)) == 3'h0);
    endproperty
    a_masked_off: assert property (p_masked_off) // [RL7]
        else $error("Masked pin change set a group flag.");

    property p_ctrl_gate;
        (ctrl_r == 3'h0) && !ctrl_wr |=> (group_request == 3'h0) && !irq;
    endproperty
    a_ctrl_gate: assert property (p_ctrl_gate) // [RL10]
        else $error("Interrupt raised with every group disabled.");

endmodule
